// [rtl/dram_cmd_map.svh]
// Constants for the clock-enable and command path of the memory device
`ifndef DRAM_CMD_MAP_SVH
`define DRAM_CMD_MAP_SVH

// ******************************************************
// Widths
// ******************************************************
`define DRAM_BANK_W       3
`define DRAM_ADDR_W       14
`define DRAM_COL_W        10
`define DRAM_AP_BIT       10
`define DRAM_MR_NUM       4

// ******************************************************
// Timing
// ******************************************************
`define DRAM_TCKE_CLK     3
`define DRAM_TXSRD_CLK    200
`define DRAM_TXSNR_CLK    200
`define DRAM_TMRD_CLK     2
`define DRAM_BUSY_CLK     16
`define DRAM_AL_DEF       3'h0

// ******************************************************
// Reset values
// ******************************************************
`define DRAM_CNT_RST      8'h00

`endif

// [rtl/dram_cmd_pkg.sv]
// Types shared by both ends of the command link
package dram_cmd_pkg;

    // Decoded command from the strobe pins
    typedef enum logic [2:0] {
        CMD_NOP  = 3'b000,
        CMD_MRS  = 3'b001,
        CMD_REF  = 3'b010,
        CMD_PRE  = 3'b011,
        CMD_ACT  = 3'b100,
        CMD_WR   = 3'b101,
        CMD_RD   = 3'b110,
        CMD_DES  = 3'b111
    } cmd_t;

    // Device power state
    typedef enum logic [2:0] {
        PS_IDLE  = 3'b000,
        PS_ACT   = 3'b001,
        PS_APD   = 3'b010,
        PS_PPD   = 3'b011,
        PS_SREF  = 3'b100
    } pstate_t;

    // Decode the four strobes; cs_n high is a deselect
    function automatic cmd_t decode(input logic cs_n, input logic ras_n,
                                    input logic cas_n, input logic we_n);
        if (cs_n) begin
            return CMD_DES;
        end
        case ({ras_n, cas_n, we_n})
            3'b000:  return CMD_MRS;
            3'b001:  return CMD_REF;
            3'b010:  return CMD_PRE;
            3'b011:  return CMD_ACT;
            3'b100:  return CMD_WR;
            3'b101:  return CMD_RD;
            default: return CMD_NOP;
        endcase
    endfunction

endpackage

// [rtl/dram_cmd_if.sv]
// Command, clock-enable and write mask pins between controller and device
`timescale 1ns/1ps
`default_nettype none
`include "dram_cmd_map.svh"
interface dram_cmd_if;
    logic                      cke;    // Clock enable
    logic                      cs_n;   // Chip select
    logic                      ras_n;  // Row strobe
    logic                      cas_n;  // Column strobe
    logic                      we_n;   // Write enable
    logic                      odt;    // Termination enable
    logic [`DRAM_BANK_W-1:0]   ba;     // Bank address
    logic [`DRAM_ADDR_W-1:0]   addr;   // Address
    logic                      dm;     // Write data mask
    logic [7:0]                dq;     // Write data

    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dm, dq);
    modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dm, dq);
endinterface
`default_nettype wire

// [rtl/dram_cmd_dev.sv]
// Device end: power state, command decode, bank rows and masked writes
//
// ******************************************************
// ******************************************************
//
`timescale 1ns/1ps
`default_nettype none
`include "dram_cmd_map.svh"
module dram_cmd_dev #(
    parameter int NBANK = 8,     // Number of banks
    parameter int DEPTH = 16     // Words kept by the small array model
) (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    dram_cmd_if.dev                         pins,
    output logic [2:0]                      pstate,
    output logic [NBANK-1:0]                bank_open,
    output logic                            odt_on,
    output logic                            rd_go,
    output logic                            wr_go,
    output logic                            ap_go,
    output logic [`DRAM_COL_W-1:0]          col_out,
    output logic [`DRAM_BANK_W-1:0]         bank_out,
    output logic [7:0]                      wr_word
);

    // ******************************************************
    // State
    // ******************************************************
    logic                      cke_prev_r;  // CKE at previous edge
    dram_cmd_pkg::pstate_t     ps_r;        // Power state
    dram_cmd_pkg::cmd_t        cmd;         // Command this edge
    logic [`DRAM_ADDR_W-1:0]   row_r [NBANK];       // Open rows
    logic [NBANK-1:0]          open_r;      // Row open per bank
    logic [`DRAM_ADDR_W-1:0]   mr_r [`DRAM_MR_NUM]; // Mode registers
    logic [2:0]                al_r;        // Additive latency
    logic [7:0]                mem_r [DEPTH];       // Small array
    logic [`DRAM_COL_W-1:0]    wcol_r;      // Pending write column
    logic                      wpend_r;     // Write beat expected
    // Additive latency pipe: valid, read, ap, bank, column
    logic [6:0]                alv_r;
    logic [6:0]                alr_r;
    logic [6:0]                ala_r;
    logic [`DRAM_BANK_W-1:0]   alb_r [7];
    logic [`DRAM_COL_W-1:0]    alc_r [7];
    logic                      issue;       // Clocked cycle, CKE high on both edges
    logic                      pd_cmd;      // NOP or deselect

    // Commands count when CKE was and is high; a refresh as CKE falls with no row open enters self refresh
    assign cmd    = dram_cmd_pkg::decode(pins.cs_n, pins.ras_n,
                                         pins.cas_n, pins.we_n);
    assign issue  = cke_prev_r && pins.cke;
    assign pd_cmd = (cmd == dram_cmd_pkg::CMD_NOP) ||
                    (cmd == dram_cmd_pkg::CMD_DES);

    // ******************************************************
    // Clock-enable history
    // ******************************************************
    // Previous CKE level for the two-edge decision
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cke_prev_r <= 1'b0;
        end else begin
            cke_prev_r <= pins.cke;
        end
    end

    // ******************************************************
    // Power state
    // ******************************************************
    // ODT never steers these transitions
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ps_r <= dram_cmd_pkg::PS_IDLE;
        end else begin
            case (ps_r)
                dram_cmd_pkg::PS_APD, dram_cmd_pkg::PS_PPD: begin
                    // Held while CKE low on both edges, no refresh
                    if (!cke_prev_r && pins.cke && pd_cmd) begin
                        ps_r <= (|open_r) ? dram_cmd_pkg::PS_ACT
                                          : dram_cmd_pkg::PS_IDLE;
                    end
                end
                dram_cmd_pkg::PS_SREF: begin
                    // A rising CKE is the wake-up; clock may have stopped
                    if (pins.cke) begin
                        ps_r <= dram_cmd_pkg::PS_IDLE;
                    end
                end
                default: begin
                    if (cke_prev_r && !pins.cke) begin
                        if (cmd == dram_cmd_pkg::CMD_REF && !(|open_r)) begin
                            ps_r <= dram_cmd_pkg::PS_SREF;
                        end else if (pd_cmd) begin
                            ps_r <= (|open_r) ? dram_cmd_pkg::PS_APD
                                              : dram_cmd_pkg::PS_PPD;
                        end
                    end else if (issue) begin
                        ps_r <= (|open_r) ? dram_cmd_pkg::PS_ACT
                                          : dram_cmd_pkg::PS_IDLE;
                    end
                end
            endcase
        end
    end

    // ******************************************************
    // Mode registers and banks
    // ******************************************************
    // Deselect and NOP fall through untouched
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            open_r <= '0;
            al_r   <= `DRAM_AL_DEF;
            for (int i = 0; i < NBANK; i++) begin
                row_r[i] <= '0;
            end
            for (int i = 0; i < `DRAM_MR_NUM; i++) begin
                mr_r[i] <= '0;
            end
        end else begin
            // Auto precharge closes the row as the burst is taken;
            // an activate on the same edge is set later and wins
            if (alv_r[0] && ala_r[0]) begin
                open_r[alb_r[0]] <= 1'b0;
            end
            if (issue) begin
                case (cmd)
                    dram_cmd_pkg::CMD_MRS: begin
                        mr_r[pins.ba[1:0]] <= pins.addr;
                        if (pins.ba[1:0] == 2'b01) begin
                            al_r <= pins.addr[5:3];
                        end
                    end
                    dram_cmd_pkg::CMD_ACT: begin
                        open_r[pins.ba]  <= 1'b1;
                        row_r[pins.ba]   <= pins.addr;
                    end
                    dram_cmd_pkg::CMD_PRE: begin
                        if (pins.addr[`DRAM_AP_BIT]) begin
                            open_r <= '0;
                        end else begin
                            open_r[pins.ba] <= 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ******************************************************
    // Additive latency pipe
    // ******************************************************
    // Slot al_r loaded; slot 0 is the internal registration
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            alv_r <= '0;
            alr_r <= '0;
            ala_r <= '0;
            for (int i = 0; i < 7; i++) begin
                alb_r[i] <= '0;
                alc_r[i] <= '0;
            end
        end else begin
            alv_r <= {1'b0, alv_r[6:1]};
            alr_r <= {1'b0, alr_r[6:1]};
            ala_r <= {1'b0, ala_r[6:1]};
            for (int i = 0; i < 6; i++) begin
                alb_r[i] <= alb_r[i+1];
                alc_r[i] <= alc_r[i+1];
            end
            if (issue && (cmd == dram_cmd_pkg::CMD_RD ||
                          cmd == dram_cmd_pkg::CMD_WR)) begin
                alv_r[al_r] <= 1'b1;
                alr_r[al_r] <= (cmd == dram_cmd_pkg::CMD_RD);
                ala_r[al_r] <= pins.addr[`DRAM_AP_BIT];
                alb_r[al_r] <= pins.ba;
                alc_r[al_r] <= pins.addr[`DRAM_COL_W-1:0];
            end
        end
    end

    // ******************************************************
    // Write data with byte mask
    // ******************************************************
    // Single beat per write keeps the model small
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wpend_r <= 1'b0;
            wcol_r  <= '0;
        end else begin
            wpend_r <= alv_r[0] && !alr_r[0];
            // Column kept until the next write so wr_word stays on it
            if (alv_r[0] && !alr_r[0]) begin
                wcol_r <= alc_r[0];
            end
            if (wpend_r && !pins.dm) begin
                mem_r[wcol_r[$clog2(DEPTH)-1:0]] <= pins.dq;
            end
        end
    end

    // ******************************************************
    // Outputs
    // ******************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_go    <= 1'b0;
            wr_go    <= 1'b0;
            ap_go    <= 1'b0;
            col_out  <= '0;
            bank_out <= '0;
            wr_word  <= '0;
        end else begin
            rd_go    <= alv_r[0] && alr_r[0];
            wr_go    <= alv_r[0] && !alr_r[0];
            ap_go    <= alv_r[0] && ala_r[0];
            col_out  <= alc_r[0];
            bank_out <= alb_r[0];
            wr_word  <= mem_r[wcol_r[$clog2(DEPTH)-1:0]];
        end
    end

    assign pstate    = ps_r;
    assign bank_open = open_r;
    // Termination follows the pin except in self refresh
    assign odt_on    = pins.odt && (ps_r != dram_cmd_pkg::PS_SREF);

endmodule
`default_nettype wire

// [rtl/dram_cmd_ctrl.sv]
// Controller end: paces CKE and commands to the device's rules
`timescale 1ns/1ps
`default_nettype none
`include "dram_cmd_map.svh"
module dram_cmd_ctrl (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       req,      // Command request
    input  wire logic [2:0]                 req_cmd,  // cmd_t code
    input  wire logic [`DRAM_BANK_W-1:0]    req_ba,
    input  wire logic [`DRAM_ADDR_W-1:0]    req_addr,
    input  wire logic                       req_cke,  // Wanted CKE level
    input  wire logic                       cal_mode, // Driver calibration
    input  wire logic                       odt_req,
    input  wire logic                       wdm,
    input  wire logic [7:0]                 wdata,
    output logic                            ready,
    dram_cmd_if.ctrl                        pins
);

    // ******************************************************
    // State
    // ******************************************************
    logic        cke_r;     // Driven CKE
    logic [7:0]  hold_r;    // Edges CKE must stay put
    logic [7:0]  xsnr_r;    // NOP-only window after self refresh
    logic [7:0]  xsrd_r;    // Read block after self refresh
    logic [7:0]  mrd_r;     // Wait after mode set
    logic [7:0]  busy_r;    // Operation still in flight
    logic        sref_r;    // Device believed in self refresh
    logic        ok;        // Request may go now
    logic        cke_tgt;   // Wanted CKE level
    dram_cmd_pkg::cmd_t rc; // Requested command

    assign rc      = dram_cmd_pkg::cmd_t'(req_cmd);
    assign cke_tgt = req_cke || cal_mode;
    // Reads also wait out tXSRD; all but NOP wait tXSNR, and all wait tMRD
    // A CKE fall also waits for operations in flight
    assign ok = (hold_r == 8'h00) && (mrd_r == 8'h00) &&
                (busy_r == 8'h00 || cke_tgt || !cke_r) &&
                (xsnr_r == 8'h00 || rc == dram_cmd_pkg::CMD_NOP) &&
                (xsrd_r == 8'h00 || rc != dram_cmd_pkg::CMD_RD);
    assign ready = ok;

    // ******************************************************
    // CKE and timers
    // ******************************************************
    // CKE only changes with NOP or self-refresh entry; callers keep
    // refresh for idle banks; power-down may leave rows open
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cke_r  <= 1'b0;
            hold_r <= `DRAM_CNT_RST;
            xsnr_r <= `DRAM_CNT_RST;
            xsrd_r <= `DRAM_CNT_RST;
            mrd_r  <= `DRAM_CNT_RST;
            busy_r <= `DRAM_CNT_RST;
            sref_r <= 1'b0;
        end else begin
            if (hold_r != 8'h00) hold_r <= hold_r - 8'h01;
            if (xsnr_r != 8'h00) xsnr_r <= xsnr_r - 8'h01;
            if (xsrd_r != 8'h00) xsrd_r <= xsrd_r - 8'h01;
            if (mrd_r  != 8'h00) mrd_r  <= mrd_r - 8'h01;
            if (busy_r != 8'h00) busy_r <= busy_r - 8'h01;
            if (req && ok && cke_tgt != cke_r) begin
                cke_r  <= cke_tgt;
                hold_r <= 8'(`DRAM_TCKE_CLK - 1);
                if (!cke_tgt) begin
                    sref_r <= (rc == dram_cmd_pkg::CMD_REF);
                end else if (sref_r) begin
                    sref_r <= 1'b0;
                    xsnr_r <= 8'(`DRAM_TXSNR_CLK);
                    xsrd_r <= 8'(`DRAM_TXSRD_CLK);
                end
            end else if (req && ok && rc == dram_cmd_pkg::CMD_MRS) begin
                mrd_r <= 8'(`DRAM_TMRD_CLK - 1);
            end
            // A burst, mode set or precharge keeps CKE from falling
            if (req && ok && cke_r && cke_tgt &&
                rc inside {dram_cmd_pkg::CMD_RD, dram_cmd_pkg::CMD_WR,
                           dram_cmd_pkg::CMD_PRE, dram_cmd_pkg::CMD_MRS}) begin
                busy_r <= 8'(`DRAM_BUSY_CLK);
            end
        end
    end

    // ******************************************************
    // Command pins
    // ******************************************************
    // Transitions carry NOP unless entering self refresh
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'hf;
            pins.ba   <= '0;
            pins.addr <= '0;
            pins.odt  <= 1'b0;
            pins.dm   <= 1'b1;
            pins.dq   <= '0;
        end else begin
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h7;
            if (req && ok) begin
                // Low CKE carries only NOP, whatever was asked
                if (!cke_r ||
                    (cke_tgt != cke_r && rc != dram_cmd_pkg::CMD_REF)) begin
                    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h7;
                end else if (rc == dram_cmd_pkg::CMD_DES) begin
                    // Chip select alone must mask the row strobe here
                    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'hb;
                end else begin
                    {pins.ras_n, pins.cas_n, pins.we_n} <=
                        (rc == dram_cmd_pkg::CMD_NOP) ? 3'h7 :
                        (rc == dram_cmd_pkg::CMD_MRS) ? 3'h0 :
                        (rc == dram_cmd_pkg::CMD_REF) ? 3'h1 :
                        (rc == dram_cmd_pkg::CMD_PRE) ? 3'h2 :
                        (rc == dram_cmd_pkg::CMD_ACT) ? 3'h3 :
                        (rc == dram_cmd_pkg::CMD_WR)  ? 3'h4 : 3'h5;
                    pins.cs_n <= 1'b0;
                end
                pins.ba   <= req_ba;
                pins.addr <= req_addr;
            end
            pins.odt <= odt_req;
            pins.dm  <= wdm;
            pins.dq  <= wdata;
        end
    end

    assign pins.cke = cke_r;

endmodule
`default_nettype wire

// [dv/dram_cmd_props.sv]
// Wire-level checker for the controller-to-device command link
`timescale 1ns/1ps
`default_nettype none
`include "dram_cmd_map.svh"
module dram_cmd_props (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    cke,
    input  wire logic                    cs_n,
    input  wire logic                    ras_n,
    input  wire logic                    cas_n,
    input  wire logic                    we_n,
    input  wire logic [`DRAM_BANK_W-1:0] ba,
    input  wire logic [`DRAM_ADDR_W-1:0] addr
);
    // ********
    // Command decode
    // ********
    wire        nop_w = cs_n | (ras_n & cas_n & we_n);  // Nothing executes
    wire        mrs_w = !nop_w & !ras_n & !cas_n & !we_n;
    wire        ref_w = !nop_w & !ras_n & !cas_n & we_n;
    wire        act_w = !nop_w & !ras_n & cas_n & we_n;
    wire        pre_w = !nop_w & !ras_n & cas_n & !we_n;
    wire        col_w = !nop_w & ras_n & !cas_n;        // Read or write
    wire        ap_w  = addr[`DRAM_AP_BIT];             // Auto precharge
    logic [7:0] open_r;                                 // Banks with a row
    logic       sref_r;                                 // In self refresh
    logic [7:0] quiet_r;                                // Edges kept silent
    // Row bookkeeping; auto precharge closes at once, the safe reading
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            open_r <= 8'h00;
        end else if (act_w) begin
            open_r[ba] <= 1'b1;
        end else if (pre_w && ap_w) begin
            open_r <= 8'h00;
        end else if (pre_w || (col_w && ap_w)) begin
            open_r[ba] <= 1'b0;
        end
    end
    // Self refresh and the silent stretch after its exit
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sref_r  <= 1'b0;
            quiet_r <= `DRAM_CNT_RST;
        end else if (sref_r && cke) begin
            sref_r  <= 1'b0;
            quiet_r <= 8'(`DRAM_TXSNR_CLK - 1);
        end else begin
            sref_r  <= sref_r | (ref_w & !cke);
            quiet_r <= (quiet_r != 8'h00) ? quiet_r - 8'h01 : quiet_r;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_cke_hold: assert property ($changed(cke) |=> $stable(cke) [*2])
        else $error("cke moved before three edges");
    a_rise_nop: assert property ($rose(cke) |-> nop_w)
        else $error("command paired with cke rise");
    a_fall_cmd: assert property ($fell(cke) |-> nop_w || ref_w)
        else $error("bad command paired with cke fall");
    a_exec_cke: assert property (!nop_w |-> $past(cke) && (cke || ref_w))
        else $error("command with cke low");
    a_mrs_gap: assert property (mrs_w |=> nop_w)
        else $error("command inside mode set gap");
    a_srx_quiet: assert property (quiet_r != 8'h00 |-> nop_w)
        else $error("command too soon after self refresh");
    a_sref_idle: assert property (ref_w |-> open_r == 8'h00)
        else $error("refresh with a row open");
    a_act_closed: assert property (act_w |-> !open_r[ba])
        else $error("activate on an open bank");
    c_sref_in: cover property (ref_w && !cke);
    c_sref_out: cover property (sref_r && cke);
    c_auto_pre: cover property (col_w && ap_w);
endmodule
`default_nettype wire

// [dv/ddr2_cke_power_and_command_control_tb_top.sv]
// Self-checking bench joining the controller and device ends
`timescale 1ns/1ps
`default_nettype none
module ddr2_cke_power_and_command_control_tb_top;
    // ********
    // Bench signals and model state
    // ********
    logic        clk, reset_n, req, req_cke, cal_mode, odt_req, wdm;
    logic [2:0]  req_cmd, req_ba, pstate, bank_out, b;
    logic [13:0] req_addr;
    logic [7:0]  wdata, bank_open, wr_word, d, exp_open;
    logic [9:0]  col_out, c;
    logic        ready, odt_on, rd_go, wr_go, ap_go;
    logic [7:0]  mem [16];                 // Model of the small array
    int          n_errors, n_checks, cyc, n, waited;
    integer      seed = 32'h0ebca936;      // Fixed for a repeatable run
    dram_cmd_if pins_if ();
    dram_cmd_ctrl dram_cmd_ctrl_inst (.clk(clk), .reset_n(reset_n),
        .req(req), .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr),
        .req_cke(req_cke), .cal_mode(cal_mode), .odt_req(odt_req),
        .wdm(wdm), .wdata(wdata), .ready(ready), .pins(pins_if));
    dram_cmd_dev #(.NBANK(8), .DEPTH(16)) dram_cmd_dev_inst (.clk(clk),
        .reset_n(reset_n), .pins(pins_if), .pstate(pstate),
        .bank_open(bank_open), .odt_on(odt_on), .rd_go(rd_go), .wr_go(wr_go),
        .ap_go(ap_go), .col_out(col_out), .bank_out(bank_out),
        .wr_word(wr_word));
    dram_cmd_props dram_cmd_props_inst (.clk(clk), .reset_n(reset_n),
        .cke(pins_if.cke), .cs_n(pins_if.cs_n), .ras_n(pins_if.ras_n),
        .cas_n(pins_if.cas_n), .we_n(pins_if.we_n), .ba(pins_if.ba),
        .addr(pins_if.addr));
    // ********
    // Tasks
    // ********
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Held until taken; waited counts refused cycles
    task automatic issue(input logic [2:0] cm, bk, input logic [13:0] ad,
                         input logic ck);
        @(posedge clk);
        req      <= 1'b1;
        req_cmd  <= cm;
        req_ba   <= bk;
        req_addr <= ad;
        req_cke  <= ck;
        waited = 0;
        @(negedge clk);
        while (ready !== 1'b1 && waited < 300) begin
            waited++;
            @(negedge clk);
        end
        if (waited == 300) n_errors++;  // Refused too long counts
        @(posedge clk);
        req <= 1'b0;
        @(negedge clk);
    endtask
    // Cycles from the taking edge to the internal start pulse
    task automatic go();
        n = 0;
        while (!(rd_go || wr_go) && n < 20) begin
            @(negedge clk);
            n++;
        end
    endtask
    // Data side and mode inputs, changed at a rising edge
    task automatic drv(input logic [7:0] dt, input logic mk, cl, od);
        @(posedge clk);
        wdata    <= dt;
        wdm      <= mk;
        cal_mode <= cl;
        odt_req  <= od;
        @(negedge clk);
    endtask
    task automatic pwr(input logic [2:0] cm, input logic ck,
                       input logic [2:0] ex);
        issue(cm, 3'h0, 14'h0000, ck);
        repeat (4) @(negedge clk);
        chk("pstate", ex, pstate);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Hang guard, far above the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        {reset_n, req, req_cke, cal_mode, odt_req} = 5'h00;
        {req_cmd, req_ba, req_addr, wdata, wdm} = 29'h1;
        exp_open = 8'h00;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk("bank_open", 0, bank_open);
        pwr(dram_cmd_pkg::CMD_NOP, 1'b1, dram_cmd_pkg::PS_IDLE);
        // Every additive latency value 0..3, write, masked write, read
        for (int al = 0; al < 4; al++) begin
            b = 3'($random(seed));
            c = 10'($random(seed));
            d = 8'($random(seed));
            issue(dram_cmd_pkg::CMD_MRS, 3'h1, 14'(al << 3), 1'b1);
            issue(dram_cmd_pkg::CMD_MRS, 3'h0, 14'($random(seed)), 1'b1);
            issue(dram_cmd_pkg::CMD_ACT, b, 14'($random(seed)), 1'b1);
            exp_open[b] = 1'b1;
            drv(d, 1'b0, 1'b0, 1'b0);
            issue(dram_cmd_pkg::CMD_WR, b, {4'h0, c}, 1'b1);
            go();
            chk("wr_lat", 16'(2 + al), 16'(n));
            chk("wr_bank", b, bank_out);
            chk("wr_ap", 0, ap_go);
            mem[c[3:0]] = d;
            drv(~d, 1'b1, 1'b0, 1'b0);
            @(negedge clk);                // Stored word shows a cycle on
            chk("wr_word", mem[c[3:0]], wr_word);
            issue(dram_cmd_pkg::CMD_WR, b, {4'h0, c}, 1'b1);
            go();
            repeat (2) @(negedge clk);
            chk("masked", mem[c[3:0]], wr_word);
            chk("bank_open", exp_open, bank_open);
            issue(dram_cmd_pkg::CMD_RD, b, {4'h1, c}, 1'b1);
            go();
            chk("rd_lat", 16'(2 + al), 16'(n));
            chk("rd_ap", 1, ap_go);
            chk("rd_col", c, col_out);
            exp_open[b] = 1'b0;
            repeat (8) @(negedge clk);
            chk("ap_close", exp_open, bank_open);
        end
        pwr(dram_cmd_pkg::CMD_NOP, 1'b0, dram_cmd_pkg::PS_PPD);
        pwr(dram_cmd_pkg::CMD_NOP, 1'b1, dram_cmd_pkg::PS_IDLE);
        issue(dram_cmd_pkg::CMD_ACT, 3'h5, 14'h0123, 1'b1);
        exp_open[5] = 1'b1;
        pwr(dram_cmd_pkg::CMD_NOP, 1'b0, dram_cmd_pkg::PS_APD);
        pwr(dram_cmd_pkg::CMD_NOP, 1'b1, dram_cmd_pkg::PS_ACT);
        // Idle and deselected cycles with random address noise
        for (int i = 0; i < 6; i++) begin
            issue(3'(i[0] ? 0 : 7), 3'($random(seed)), 14'($random(seed)), 1);
        end
        chk("nop_keep", exp_open, bank_open);
        drv(8'h00, 1'b1, 1'b1, 1'b0);
        pwr(dram_cmd_pkg::CMD_NOP, 1'b0, dram_cmd_pkg::PS_ACT);
        chk("cal_cke", 1, pins_if.cke);
        pwr(dram_cmd_pkg::CMD_NOP, 1'b1, dram_cmd_pkg::PS_ACT);
        drv(8'h00, 1'b1, 1'b0, 1'b1);
        issue(dram_cmd_pkg::CMD_PRE, 3'h0, 14'h0400, 1'b1);
        exp_open = 8'h00;
        pwr(dram_cmd_pkg::CMD_REF, 1'b0, dram_cmd_pkg::PS_SREF);
        chk("sref_odt", 0, odt_on);
        chk("sref_cke", 0, pins_if.cke);
        pwr(dram_cmd_pkg::CMD_NOP, 1'b1, dram_cmd_pkg::PS_IDLE);
        issue(dram_cmd_pkg::CMD_ACT, 3'h2, 14'h0042, 1'b1);
        chk("srx_wait", 1, waited inside {[180:205]});
        repeat (4) @(negedge clk);
        chk("odt_back", 1, odt_on);
        chk("bank_open", 8'h04, bank_open);
        conclude();
    end
endmodule
`default_nettype wire
